// *** inc/repeater_pkg.sv ***
// constants shared by the setup-register device end and the agent end
// assumes one 20 MHz clock and one serial data line resolved in the link
package repeater_pkg;
  // serial frame: 2 start, 2 op, 5 device, 5 register, 2 turnaround, 16 data
  localparam logic [1:0] FRAME_START = 2'h1;
  localparam logic [1:0] OP_READ = 2'h2;
  localparam logic [1:0] OP_WRITE = 2'h1;
  localparam logic [1:0] TA_WRITE = 2'h2;
  localparam logic [4:0] BIT_START1 = 5'h01;
  localparam logic [4:0] BIT_HDR_END = 5'h0D;
  localparam logic [4:0] BIT_TA_FIRST = 5'h0E;
  localparam logic [4:0] BIT_DATA_FIRST = 5'h10;
  localparam logic [4:0] BIT_LAST = 5'h1F;
  // header field positions once bits 0..13 sit in the low 14 bits
  localparam int HDR_OP_HI = 11;
  localparam int HDR_OP_LO = 10;
  localparam int HDR_DEV_HI = 9;
  localparam int HDR_DEV_LO = 5;
  localparam int HDR_REG_HI = 4;
  localparam int HDR_REG_LO = 0;
  // device register offsets, same on every page
  localparam logic [4:0] REG_SETUP = 5'h00;
  localparam logic [4:0] REG_PAGE = 5'h01;
  // setup register fields and the page reset value
  localparam int SETUP_REGEN = 5;
  localparam int SETUP_CNT_EN = 4;
  localparam int SETUP_COL32 = 3;
  localparam int SETUP_PART_DIS = 2;
  localparam int SETUP_PHY_PASS = 1;
  localparam int SETUP_HOLD = 0;
  localparam logic [1:0] PAGE_RESET = 2'h0;
  // timing, in clocks, and the two collision limits
  localparam logic [3:0] TX_REGEN_CLKS = 4'h4;
  localparam logic [3:0] T4_REGEN_CLKS = 4'hC;
  localparam logic [6:0] COL_LIMIT_64 = 7'h40;
  localparam logic [6:0] COL_LIMIT_32 = 7'h20;
  localparam logic [2:0] SCLK_HALF = 3'h4;
  // agent register map on AXI4-Lite
  localparam logic [7:0] AG_CTRL = 8'h00;
  localparam logic [7:0] AG_WDATA = 8'h04;
  localparam logic [7:0] AG_STATUS = 8'h08;
  localparam logic [7:0] AG_RDATA = 8'h0C;
  localparam int CTRL_READ = 0;
  localparam int CTRL_DEV_LO = 8;
  localparam int CTRL_REG_LO = 16;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic {F_IDLE, F_SHIFT} frame_st_t;
endpackage

// *** inc/reg_link_if.sv ***
// serial register link between the management agent and the device
// the data line idles high; no driver enabled reads as one
`timescale 1ns/1ps
interface reg_link_if;
  logic sclk;
  logic agent_o;
  logic agent_oe;
  logic dev_o;
  logic dev_oe;
  logic line;
  assign line = agent_oe ? agent_o : (dev_oe ? dev_o : 1'b1);
  modport agent (output sclk, output agent_o, output agent_oe,
                 input line);
  modport device (input sclk, input line, output dev_o, output dev_oe);
endinterface

// *** core/repeater_setup_dev.sv ***
// device end: setup and page registers behind the serial register link,
// the preamble start delay and the configuration outputs
// assumes link inputs and pins are synchronous to mclk
`timescale 1ns/1ps
// Behaviour
// - setup register at offset zero on every page
// - software writes zero to bits 15..6
// - pins 1,1 set regen bit; writes override
// - TX: preamble starts four clocks after activity
// - T4: preamble starts twelve clocks after activity
// - bit 4 enables management counters, default off
// - software writes counters only while disabled
// - bit 3 zero: limit 64, partition on 65th
// - bit 3 one: limit 32, partition on 33rd
// - bit 2 disables auto-partitioning for all ports
// - bit 1 enables PHY register pass-through
// - pass-through: drive data during every read phase
// - pass-through: agent addresses only device or PHYs
// - bit 0 holds repeater state machines in reset
// - hold during reception may truncate packet
// - page field: 0 page0 default, 1 page1
module repeater_setup_dev
  import repeater_pkg::*;
#(
  parameter logic [4:0] DEV_ADDR = 5'h01
) (
  input wire logic mclk,
  input wire logic rst,
  reg_link_if.device link,
  input wire logic [1:0] mode_pins,
  input wire logic bus_activity_n,
  input wire logic phy_serial_data,
  output logic preamble_regen_select,
  output logic counter_enable,
  output logic collision_limit_select,
  output logic partition_disable,
  output logic phy_passthrough_enable,
  output logic state_machine_hold,
  output logic [1:0] page_select,
  output logic [6:0] collision_limit,
  output logic regen_start
);
  logic sclk_d_r;
  logic rise;
  logic fall;
  frame_st_t st_r;
  logic [4:0] cnt_r;
  logic [15:0] sh_r;
  logic [15:0] sh_nxt;
  logic rd_r;
  logic wr_r;
  logic hit_r;
  logic [4:0] reg_r;
  logic wr_fire;
  logic [15:0] tx_r;
  logic [15:0] rd_val;
  logic dev_o_r;
  logic dev_oe_r;
  logic strap_done_r;
  logic act_d_r;
  logic [3:0] dly_r;
  logic [6:0] limit_r;
  logic regen_r;

  assign link.dev_o = dev_o_r;
  assign link.dev_oe = dev_oe_r;
  assign collision_limit = limit_r;
  assign regen_start = regen_r;

  assign rise = link.sclk & ~sclk_d_r;
  assign fall = ~link.sclk & sclk_d_r;
  assign sh_nxt = {sh_r[14:0], link.line};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sclk_d_r <= 1'b0;
    end else begin
      sclk_d_r <= link.sclk;
    end
  end

  // frame receiver; a bad second start bit drops the frame
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= F_IDLE;
      cnt_r <= 5'h00;
      sh_r <= 16'h0000;
      rd_r <= 1'b0;
      wr_r <= 1'b0;
      hit_r <= 1'b0;
      reg_r <= 5'h00;
    end else begin
      case (st_r)
        F_IDLE: begin
          if (rise && !link.line) begin
            st_r <= F_SHIFT;
            cnt_r <= BIT_START1;
            sh_r <= 16'h0000;
            rd_r <= 1'b0;
            wr_r <= 1'b0;
          end
        end
        F_SHIFT: begin
          if (rise) begin
            sh_r <= sh_nxt;
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == BIT_START1 && !link.line) begin
              st_r <= F_IDLE;
            end
            if (cnt_r == BIT_HDR_END) begin
              rd_r <= sh_nxt[HDR_OP_HI:HDR_OP_LO] == OP_READ;
              wr_r <= sh_nxt[HDR_OP_HI:HDR_OP_LO] == OP_WRITE;
              hit_r <= sh_nxt[HDR_DEV_HI:HDR_DEV_LO] == DEV_ADDR;
              reg_r <= sh_nxt[HDR_REG_HI:HDR_REG_LO];
            end
            if (cnt_r == BIT_LAST) begin
              st_r <= F_IDLE;
            end
          end
        end
        default: st_r <= F_IDLE;
      endcase
    end
  end

  assign wr_fire = (st_r == F_SHIFT) && rise && (cnt_r == BIT_LAST) &&
                   wr_r && hit_r;

  // page is ignored for offsets 0 and 1, so both pages see them
  // upper bits read as zero; the far side must write them as zero
  always_comb begin
    rd_val = 16'h0000;
    if (sh_nxt[HDR_REG_HI:HDR_REG_LO] == REG_SETUP) begin
      rd_val[SETUP_REGEN] = preamble_regen_select;
      rd_val[SETUP_CNT_EN] = counter_enable;
      rd_val[SETUP_COL32] = collision_limit_select;
      rd_val[SETUP_PART_DIS] = partition_disable;
      rd_val[SETUP_PHY_PASS] = phy_passthrough_enable;
      rd_val[SETUP_HOLD] = state_machine_hold;
    end else if (sh_nxt[HDR_REG_HI:HDR_REG_LO] == REG_PAGE) begin
      rd_val[1:0] = page_select;
    end
  end

  // pins are caught on the first edge after reset release
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      strap_done_r <= 1'b0;
      preamble_regen_select <= 1'b0;
      counter_enable <= 1'b0;
      collision_limit_select <= 1'b0;
      partition_disable <= 1'b0;
      phy_passthrough_enable <= 1'b0;
      state_machine_hold <= 1'b0;
    end else begin
      if (!strap_done_r) begin
        strap_done_r <= 1'b1;
        preamble_regen_select <= &mode_pins;
      end
      if (wr_fire && reg_r == REG_SETUP) begin
        preamble_regen_select <= sh_nxt[SETUP_REGEN];
        counter_enable <= sh_nxt[SETUP_CNT_EN];
        collision_limit_select <= sh_nxt[SETUP_COL32];
        partition_disable <= sh_nxt[SETUP_PART_DIS];
        phy_passthrough_enable <= sh_nxt[SETUP_PHY_PASS];
        state_machine_hold <= sh_nxt[SETUP_HOLD];
      end
    end
  end

  // reserved page codes are stored as written; only 0 and 1 are used
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      page_select <= PAGE_RESET;
    end else if (wr_fire && reg_r == REG_PAGE) begin
      page_select <= sh_nxt[1:0];
    end
  end

  // read phase driver; in pass-through the PHY data is relayed for
  // frames aimed elsewhere, so a third target would fight the line
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tx_r <= 16'h0000;
      dev_o_r <= 1'b1;
      dev_oe_r <= 1'b0;
    end else begin
      if (st_r == F_SHIFT && rise && cnt_r == BIT_HDR_END) begin
        tx_r <= rd_val;
      end
      if (st_r != F_SHIFT || !rd_r) begin
        dev_oe_r <= 1'b0;
        dev_o_r <= 1'b1;
      end else if (fall && cnt_r >= BIT_DATA_FIRST) begin
        dev_oe_r <= hit_r | phy_passthrough_enable;
        dev_o_r <= hit_r ? tx_r[15] : phy_serial_data;
        tx_r <= {tx_r[14:0], 1'b0};
      end
    end
  end

  // preamble start delay; the hold bit clears it at once, which is
  // why a frame in flight can be cut short
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      act_d_r <= 1'b1;
      dly_r <= 4'h0;
      regen_r <= 1'b0;
    end else begin
      act_d_r <= bus_activity_n;
      regen_r <= 1'b0;
      if (state_machine_hold) begin
        dly_r <= 4'h0;
      end else if (act_d_r && !bus_activity_n) begin
        dly_r <= preamble_regen_select ? TX_REGEN_CLKS :
                 T4_REGEN_CLKS;
      end else if (dly_r != 4'h0) begin
        dly_r <= dly_r - 4'h1;
        regen_r <= dly_r == 4'h1;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      limit_r <= COL_LIMIT_64;
    end else begin
      limit_r <= collision_limit_select ? COL_LIMIT_32 :
                 COL_LIMIT_64;
    end
  end
endmodule

// *** core/mgmt_agent.sv ***
// agent end: AXI4-Lite command registers driving serial frames to the
// device; it makes the serial clock by dividing mclk
// assumes one AXI master with at most one write and one read in flight
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
module mgmt_agent
  import repeater_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  reg_link_if.agent link,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  logic aw_got_r;
  logic w_got_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_do;
  logic start;
  logic [31:0] ctrl_r;
  logic [15:0] wd_r;
  logic done_r;
  logic [15:0] rdat_r;
  logic busy_r;
  logic sclk_r;
  logic so_r;
  logic oe_r;
  logic [31:0] frame_r;
  logic [4:0] bit_r;
  logic [2:0] div_r;
  logic rd_op_r;
  logic [15:0] rsh_r;
  logic tick;
  logic fin;

  assign link.sclk = sclk_r;
  assign link.agent_o = so_r;
  assign link.agent_oe = oe_r;

  assign wr_do = aw_got_r && w_got_r && !s_axi_bvalid;
  assign start = wr_do && awaddr_r == AG_CTRL && wstrb_r != 4'h0 &&
                 !busy_r;
  assign tick = busy_r && div_r == SCLK_HALF - 3'h1;
  assign fin = tick && sclk_r && bit_r == BIT_LAST;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 8'h00;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else begin
      if (s_axi_awready && s_axi_awvalid) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_got_r && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wready && s_axi_wvalid) begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_got_r && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_do) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_r == AG_CTRL || awaddr_r == AG_WDATA ||
                        awaddr_r == AG_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // a command written while busy is dropped; software polls busy first
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_r <= 32'h00000000;
      wd_r <= 16'h0000;
    end else begin
      if (start) begin
        ctrl_r <= wdata_r;
      end
      if (wr_do && awaddr_r == AG_WDATA) begin
        if (wstrb_r[0]) begin
          wd_r[7:0] <= wdata_r[7:0];
        end
        if (wstrb_r[1]) begin
          wd_r[15:8] <= wdata_r[15:8];
        end
      end
    end
  end

  // done is set by the frame end and cleared by writing one; set wins
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      done_r <= 1'b0;
      rdat_r <= 16'h0000;
    end else begin
      if (fin) begin
        done_r <= 1'b1;
        rdat_r <= rsh_r;
      end else if (wr_do && awaddr_r == AG_STATUS && wstrb_r[0] &&
                   wdata_r[STAT_DONE]) begin
        done_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arready && s_axi_arvalid) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= RESP_OKAY;
        if (s_axi_araddr == AG_CTRL) begin
          s_axi_rdata <= ctrl_r;
        end else if (s_axi_araddr == AG_WDATA) begin
          s_axi_rdata <= {16'h0000, wd_r};
        end else if (s_axi_araddr == AG_STATUS) begin
          s_axi_rdata <= {30'h00000000, done_r, busy_r};
        end else if (s_axi_araddr == AG_RDATA) begin
          s_axi_rdata <= {16'h0000, rdat_r};
        end else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid && !s_axi_arready) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // frame engine: data changes on the falling edge, read data sampled
  // on the rising edge; the line is released from turnaround on reads.
  // register 0 reaches setup on any page, register 1 picks the page;
  // with pass-through on only the device or its PHYs may be named
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      busy_r <= 1'b0;
      sclk_r <= 1'b0;
      so_r <= 1'b1;
      oe_r <= 1'b0;
      frame_r <= 32'h00000000;
      bit_r <= 5'h00;
      div_r <= 3'h0;
      rd_op_r <= 1'b0;
      rsh_r <= 16'h0000;
    end else if (!busy_r) begin
      if (start) begin
        busy_r <= 1'b1;
        rd_op_r <= wdata_r[CTRL_READ];
        frame_r <= {FRAME_START,
                    wdata_r[CTRL_READ] ? OP_READ : OP_WRITE,
                    wdata_r[CTRL_DEV_LO +: 5],
                    wdata_r[CTRL_REG_LO +: 5],
                    TA_WRITE, wd_r};
        so_r <= 1'b0;
        oe_r <= 1'b1;
        bit_r <= 5'h00;
        div_r <= 3'h0;
        sclk_r <= 1'b0;
      end
    end else if (tick) begin
      div_r <= 3'h0;
      sclk_r <= ~sclk_r;
      if (!sclk_r) begin
        if (rd_op_r && bit_r >= BIT_DATA_FIRST) begin
          rsh_r <= {rsh_r[14:0], link.line};
        end
      end else if (bit_r == BIT_LAST) begin
        busy_r <= 1'b0;
        oe_r <= 1'b0;
        so_r <= 1'b1;
      end else begin
        bit_r <= bit_r + 5'h01;
        frame_r <= {frame_r[30:0], 1'b0};
        so_r <= frame_r[30];
        oe_r <= !(rd_op_r && (bit_r + 5'h01) >= BIT_TA_FIRST);
      end
    end else begin
      div_r <= div_r + 3'h1;
    end
  end
endmodule

// *** bench/repeater_setup_props.sv ***
// concurrent checks on the serial link and the device end's outputs
// assumes the bench's mclk and asynchronous active-high rst
`timescale 1ns/1ps
module repeater_setup_props
  import repeater_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic agent_oe,
  input wire logic dev_oe,
  input wire logic [1:0] mode_pins,
  input wire logic bus_activity_n,
  input wire logic preamble_regen_select,
  input wire logic state_machine_hold,
  input wire logic collision_limit_select,
  input wire logic [6:0] collision_limit,
  input wire logic regen_start
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_regen_tx_delay: assert property (
    $fell(bus_activity_n) && preamble_regen_select && !state_machine_hold
    |-> ##1 !regen_start [*4] ##1 regen_start)
    else $error("tx preamble start not after four clocks");
  a_regen_t4_delay: assert property (
    $fell(bus_activity_n) && !preamble_regen_select && !state_machine_hold
    |-> ##1 !regen_start [*8] ##1 !regen_start [*4] ##1 regen_start)
    else $error("t4 preamble start not after twelve clocks");
  a_regen_one_pulse: assert property (
    regen_start |=> !regen_start)
    else $error("preamble start longer than one cycle");
  // one settled cycle of hold must have cleared any pending start
  a_hold_no_start: assert property (
    state_machine_hold && $past(state_machine_hold) |-> !regen_start)
    else $error("preamble start while state machines held");
  a_limit_sixty_four: assert property (
    !collision_limit_select && !$past(collision_limit_select)
    |-> collision_limit == COL_LIMIT_64)
    else $error("collision limit not 64");
  a_limit_thirty_two: assert property (
    collision_limit_select && $past(collision_limit_select)
    |-> collision_limit == COL_LIMIT_32)
    else $error("collision limit not 32");
  a_strap_capture: assert property (
    $fell(rst) |=> preamble_regen_select == (mode_pins == 2'h3))
    else $error("regen bit not taken from mode pins");
  a_line_no_fight: assert property (
    dev_oe |-> !agent_oe)
    else $error("both ends drive the data line");
endmodule

// *** bench/repeater_setup_register_test.sv ***
// table-driven bench for the setup register across the serial link
// assumes the agent and device ends meet in reg_link_if, AXI4-Lite driven
`timescale 1ns/1ps
module repeater_setup_register_test;
  import repeater_pkg::*;
  localparam logic [4:0] DEV = 5'h01;
  typedef struct packed {logic [4:0] addr; logic [15:0] val;} row_t;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] mode_pins = 2'h1;
  logic bus_activity_n = 1'b1;
  logic phy_serial_data = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, s;
  logic regen, cnt_en, col_sel, part_dis, phy_pass, hold, pulse;
  logic [1:0] page, r;
  logic [6:0] limit;
  logic [15:0] rv;
  wire logic [5:0] bits = {regen, cnt_en, col_sel, part_dis, phy_pass, hold};
  int err_count = 0;
  int checked = 0;
  int n;
  // upper bits go as zero; no counter is ever written here
  row_t rows [10] = '{'{5'h00, 16'h0001}, '{5'h00, 16'h0002},
    '{5'h00, 16'h0004}, '{5'h00, 16'h0008}, '{5'h00, 16'h0010},
    '{5'h00, 16'h0020}, '{5'h01, 16'h0001}, '{5'h00, 16'h003D},
    '{5'h01, 16'h0000}, '{5'h00, 16'h0000}};

  always #25 mclk = ~mclk;

  reg_link_if link_i();
  repeater_setup_dev #(.DEV_ADDR(DEV)) i_repeater_setup_dev (.mclk(mclk),
    .rst(rst), .link(link_i), .mode_pins(mode_pins),
    .bus_activity_n(bus_activity_n), .phy_serial_data(phy_serial_data),
    .preamble_regen_select(regen), .counter_enable(cnt_en),
    .collision_limit_select(col_sel), .partition_disable(part_dis),
    .phy_passthrough_enable(phy_pass), .state_machine_hold(hold),
    .page_select(page), .collision_limit(limit), .regen_start(pulse));
  mgmt_agent i_mgmt_agent (.mclk(mclk), .rst(rst), .link(link_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  repeater_setup_props i_repeater_setup_props (.mclk(mclk), .rst(rst),
    .agent_oe(link_i.agent_oe), .dev_oe(link_i.dev_oe),
    .mode_pins(mode_pins), .bus_activity_n(bus_activity_n),
    .preamble_regen_select(regen), .state_machine_hold(hold),
    .collision_limit_select(col_sel), .collision_limit(limit),
    .regen_start(pulse));

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // entered just after a rising edge; each channel released once taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge mclk);
      if (awvalid && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (wvalid && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge mclk); while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge mclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge mclk); while (rvalid !== 1'b1);
    s = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask

  // one serial frame; the done flag is polled, then cleared
  task automatic frame(input logic op, input logic [4:0] dev, ra,
                       input logic [15:0] wv);
    axi_wr(AG_WDATA, {16'h0, wv});
    axi_wr(AG_CTRL, {11'h0, ra, 3'h0, dev, 7'h0, op});
    s = 32'h0;
    while (s[STAT_DONE] !== 1'b1) axi_rd(AG_STATUS);
    axi_wr(AG_STATUS, 32'h2);
    axi_rd(AG_RDATA);
    rv = s[15:0];
  endtask

  task automatic do_reset(input logic [1:0] pins);
    mode_pins <= pins;
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask

  // cycles from activity to the start pulse; 20 means none came
  task automatic measure();
    bus_activity_n <= 1'b0;
    n = 0;
    do begin
      @(posedge mclk);
      #1;
      n++;
    end while (pulse !== 1'b1 && n < 20);
    @(posedge mclk);
    bus_activity_n <= 1'b1;
    repeat (16) @(posedge mclk);
  endtask

  initial begin
    do_reset(2'h1);
    chk("reset bits", 32'(bits), 32'h0);
    chk("reset page", 32'(page), 32'h0);
    chk("reset limit", 32'(limit), 32'h40);
    foreach (rows[i]) begin
      frame(1'b0, DEV, rows[i].addr, rows[i].val);
      frame(1'b1, DEV, rows[i].addr, 16'h0);
      if (rows[i].addr == REG_SETUP) begin
        chk("setup read", 32'(rv[5:0]), 32'(rows[i].val[5:0]));
        chk("setup bits", 32'(bits), 32'(rows[i].val[5:0]));
        chk("limit", 32'(limit), rows[i].val[3] ? 32'h20 : 32'h40);
      end else begin
        chk("page", 32'(page), 32'(rows[i].val[1:0]));
      end
    end
    axi_rd(8'h10);
    chk("unmapped rd", 32'(r), 32'(RESP_SLVERR));
    axi_wr(8'h10, 32'h1);
    chk("unmapped wr", 32'(r), 32'(RESP_SLVERR));
    phy_serial_data <= 1'b0;
    frame(1'b0, DEV, REG_SETUP, 16'h0002);
    frame(1'b1, 5'h07, REG_SETUP, 16'h0);
    chk("relayed read", 32'(rv), 32'h0);
    frame(1'b0, DEV, REG_SETUP, 16'h0000);
    frame(1'b1, 5'h07, REG_SETUP, 16'h0);
    chk("unrelayed read", 32'(rv), 32'hFFFF);
    do_reset(2'h3);
    chk("strap regen", 32'(regen), 32'h1);
    measure();
    chk("tx delay", 32'(n), 32'h5);
    frame(1'b0, DEV, REG_SETUP, 16'h0000);
    chk("regen override", 32'(regen), 32'h0);
    measure();
    chk("t4 delay", 32'(n), 32'hD);
    frame(1'b0, DEV, REG_SETUP, 16'h0021);
    measure();
    chk("held start", 32'(n), 32'h14);
    complete_run();
  end

  // the longest run is about 30 frames of some 320 cycles each
  initial begin
    repeat (60000) @(posedge mclk);
    err_count++;
    complete_run();
  end
endmodule
